// ==== dcc_pkg.sv ====
package dcc_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int PD_W = 8;
    localparam int CLK_MHZ = 50;

    // ********************************************************
    // Timing, printed unit then cycles at 50 MHz
    // ********************************************************
    localparam int POWERUP_US = 100;
    localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
    localparam int REFRESH_MS = 128;
    localparam int REFRESH_ROWS = 1024;
    localparam int REFRESH_CYC = (REFRESH_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
    localparam int WAKEUP_REFRESHES = 8;
    // Phase length covers every ns-scale strobe minimum at 20 ns
    localparam int PHASE_CYC = 4;
    localparam logic [2:0] PHASE_LAST = 3'h3;

    // ********************************************************
    // Commands and states
    // ********************************************************
    typedef enum logic [2:0] {
        DCC_CMD_READ = 3'h0,
        DCC_CMD_EARLY_WRITE = 3'h1,
        DCC_CMD_LATE_WRITE = 3'h2,
        DCC_CMD_RMW = 3'h3,
        DCC_CMD_REFRESH_ROW = 3'h4,
        DCC_CMD_REFRESH_CBR = 3'h5,
        DCC_CMD_TEST_ENTRY = 3'h6
    } dcc_cmd_e;

    typedef enum logic [8:0] {
        DCC_ST_POWERUP = 9'h001,
        DCC_ST_WAKE = 9'h002,
        DCC_ST_IDLE = 9'h004,
        DCC_ST_ROW = 9'h008,
        DCC_ST_COL = 9'h010,
        DCC_ST_WRITE = 9'h020,
        DCC_ST_CBR_PRE = 9'h040,
        DCC_ST_CBR_ROW = 9'h080,
        DCC_ST_PRECHARGE = 9'h100
    } dcc_state_e;

    typedef struct packed {
        dcc_cmd_e cmd;
        logic bank_high;
        logic [LANES-1:0] lanes;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } dcc_req_s;

    typedef struct packed {
        logic row_low_n;
        logic row_high_n;
        logic [LANES-1:0] col_n;
        logic write_n;
        logic out_en_n;
        logic [ADDR_W-1:0] addr;
    } dcc_pins_s;

endpackage

// ==== dcc_interval.sv ====
`timescale 1ns/1ps

// Refresh interval timer; flags due, and flags overrun past two intervals
module dcc_interval (
    input wire logic clock,
    input wire logic rst,
    input wire logic served,
    output logic due,
    output logic overrun
);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;

    // ********************************************************
    // Counter
    // ********************************************************
    // Restart on every refresh served; saturate so overrun stays seen
    always_comb begin
        nxt_cnt = cnt_ff;
        if (served) begin
            nxt_cnt = 32'h0000_0000;
        end else if (cnt_ff != 32'hFFFF_FFFF) begin
            nxt_cnt = cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_ff <= 32'h0000_0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign due = cnt_ff >= 32'(dcc_pkg::REFRESH_CYC);
    assign overrun = cnt_ff >= 32'(2 * dcc_pkg::REFRESH_CYC);

endmodule // dcc_interval

// ==== dcc_host.sv ====
`timescale 1ns/1ps

// What this block does
// - Hold read command past column strobe rise
// - Write low around column-first enters test
// - Late write: output-enable high, write late
// - Data valid from the falling strobe used
// - Output-enable is driven, never tied low
// - Raise output-enable before write data
// - 1024 refreshes every 128 ms
// - One 32-bit array, banks selectable
// - Bank and lane selection independent
// - Presence pins captured after reset
// - Wait 100 us then eight wake refreshes
// - Write level before column picks cycle
// - Column strobe high between cycles
// - Row strobe rise ends the access
module dcc_host #(
    parameter int POWERUP_WAIT = dcc_pkg::POWERUP_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire dcc_pkg::dcc_req_s req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [dcc_pkg::DATA_W-1:0] rdata,
    output logic rdata_valid,
    output logic busy_init,
    output logic refresh_late,
    output dcc_pkg::dcc_pins_s pins,
    input wire logic [dcc_pkg::DATA_W-1:0] data_lines_in,
    output logic [dcc_pkg::DATA_W-1:0] data_lines_out,
    output logic [dcc_pkg::DATA_W-1:0] data_lines_oe_n,
    input wire logic [dcc_pkg::PD_W-1:0] presence_id_pins,
    output logic [dcc_pkg::PD_W-1:0] presence_id
);

    dcc_pkg::dcc_state_e state_ff, nxt_state;
    dcc_pkg::dcc_req_s cur_ff, nxt_cur;
    dcc_pkg::dcc_pins_s pins_ff, nxt_pins;
    logic [31:0] wait_ff, nxt_wait;
    logic [3:0] wake_ff, nxt_wake;
    logic drive_ff, nxt_drive;
    logic [dcc_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic pd_done_ff, nxt_pd_done;
    logic [dcc_pkg::PD_W-1:0] pd_ff, nxt_pd;
    logic served;
    logic due;
    logic overrun;
    logic phase_end;

    // ********************************************************
    // Refresh interval
    // ********************************************************
    dcc_interval u_interval (
        .clock(clock),
        .rst(rst),
        .served(served),
        .due(due),
        .overrun(overrun)
    );

    assign phase_end = wait_ff[2:0] == dcc_pkg::PHASE_LAST;
    assign served = state_ff == dcc_pkg::DCC_ST_PRECHARGE && phase_end
        && (cur_ff.cmd == dcc_pkg::DCC_CMD_REFRESH_ROW
        || cur_ff.cmd == dcc_pkg::DCC_CMD_REFRESH_CBR);

    // ********************************************************
    // Sequencer
    // ********************************************************
    // Each phase lasts PHASE_CYC cycles; 80 ns clears all strobe minimums
    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_pins = pins_ff;
        nxt_wait = wait_ff + 32'h0000_0001;
        nxt_wake = wake_ff;
        nxt_drive = drive_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_pd_done = 1'b1;
        nxt_pd = pd_done_ff ? pd_ff : presence_id_pins;
        unique case (state_ff)
            dcc_pkg::DCC_ST_POWERUP: begin
                if (wait_ff >= 32'(POWERUP_WAIT)) begin
                    nxt_state = dcc_pkg::DCC_ST_WAKE;
                    nxt_wake = 4'h0;
                end
            end
            dcc_pkg::DCC_ST_WAKE, dcc_pkg::DCC_ST_IDLE: begin
                nxt_wait = 32'h0000_0000;
                nxt_cur.row = cur_ff.row + 10'h001;
                nxt_cur.lanes = 4'h0;
                if (state_ff == dcc_pkg::DCC_ST_WAKE) begin
                    // Eight row-only refreshes before first access
                    if (wake_ff == 4'(dcc_pkg::WAKEUP_REFRESHES)) begin
                        nxt_state = dcc_pkg::DCC_ST_IDLE;
                        nxt_wake = 4'h0;
                    end else begin
                        nxt_wake = wake_ff + 4'h1;
                        nxt_cur.cmd = dcc_pkg::DCC_CMD_REFRESH_ROW;
                        nxt_cur.bank_high = 1'b0;
                        nxt_state = dcc_pkg::DCC_ST_ROW;
                    end
                end else if (overrun) begin
                    nxt_state = dcc_pkg::DCC_ST_WAKE;
                    nxt_wake = 4'h0;
                end else if (due) begin
                    // Column-first refresh uses the internal counter
                    nxt_cur.cmd = dcc_pkg::DCC_CMD_REFRESH_CBR;
                    nxt_state = dcc_pkg::DCC_ST_CBR_PRE;
                end else if (req_valid) begin
                    nxt_cur = req;
                    if (req.cmd == dcc_pkg::DCC_CMD_REFRESH_CBR
                        || req.cmd == dcc_pkg::DCC_CMD_TEST_ENTRY) begin
                        nxt_state = dcc_pkg::DCC_ST_CBR_PRE;
                    end else begin
                        nxt_state = dcc_pkg::DCC_ST_ROW;
                    end
                end
                nxt_pins.addr = nxt_cur.row;
                nxt_pins.write_n = !(nxt_state != state_ff
                    && nxt_cur.cmd == dcc_pkg::DCC_CMD_EARLY_WRITE);
                nxt_pins.out_en_n = 1'b1;
                // Decided on the new command; the stored one is stale here
                if (nxt_state == dcc_pkg::DCC_ST_ROW) begin
                    nxt_pins.out_en_n = !(nxt_cur.cmd == dcc_pkg::DCC_CMD_READ
                        || nxt_cur.cmd == dcc_pkg::DCC_CMD_RMW);
                end
            end
            dcc_pkg::DCC_ST_ROW: begin
                // Only the addressed bank's row strobe falls
                nxt_pins.row_low_n = cur_ff.bank_high;
                nxt_pins.row_high_n = !cur_ff.bank_high;
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    nxt_pins.addr = cur_ff.col;
                    nxt_state = cur_ff.cmd == dcc_pkg::DCC_CMD_REFRESH_ROW
                        ? dcc_pkg::DCC_ST_PRECHARGE : dcc_pkg::DCC_ST_COL;
                    if (cur_ff.cmd == dcc_pkg::DCC_CMD_EARLY_WRITE) begin
                        nxt_drive = 1'b1;
                    end
                end
            end
            dcc_pkg::DCC_ST_COL: begin
                nxt_pins.col_n = ~cur_ff.lanes;
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    if (cur_ff.cmd == dcc_pkg::DCC_CMD_READ
                        || cur_ff.cmd == dcc_pkg::DCC_CMD_RMW) begin
                        // Sample only in a defined read phase
                        nxt_rdata = data_lines_in;
                        nxt_rvalid = 1'b1;
                    end
                    if (cur_ff.cmd == dcc_pkg::DCC_CMD_LATE_WRITE
                        || cur_ff.cmd == dcc_pkg::DCC_CMD_RMW) begin
                        // Outputs off before data is driven
                        nxt_pins.out_en_n = 1'b1;
                        nxt_state = dcc_pkg::DCC_ST_WRITE;
                    end else begin
                        nxt_state = dcc_pkg::DCC_ST_PRECHARGE;
                    end
                end
            end
            dcc_pkg::DCC_ST_WRITE: begin
                // Disable time passes in the first phase cycles
                if (wait_ff[2:0] == 3'h1) begin
                    nxt_drive = 1'b1;
                end
                if (wait_ff[2:0] == 3'h2) begin
                    nxt_pins.write_n = 1'b0;
                end
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    nxt_state = dcc_pkg::DCC_ST_PRECHARGE;
                end
            end
            dcc_pkg::DCC_ST_CBR_PRE: begin
                // Column first; write level chooses refresh or test entry
                nxt_pins.col_n = 4'h0;
                nxt_pins.write_n = cur_ff.cmd != dcc_pkg::DCC_CMD_TEST_ENTRY;
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    nxt_state = dcc_pkg::DCC_ST_CBR_ROW;
                end
            end
            dcc_pkg::DCC_ST_CBR_ROW: begin
                nxt_pins.row_low_n = 1'b0;
                nxt_pins.row_high_n = 1'b0;
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    nxt_state = dcc_pkg::DCC_ST_PRECHARGE;
                end
            end
            dcc_pkg::DCC_ST_PRECHARGE: begin
                // Row rise ends access; column high clears outputs
                nxt_pins.row_low_n = 1'b1;
                nxt_pins.row_high_n = 1'b1;
                nxt_pins.col_n = 4'hF;
                nxt_drive = 1'b0;
                if (wait_ff[2:0] == 3'h1) begin
                    // Write held until both strobes are up
                    nxt_pins.write_n = 1'b1;
                    nxt_pins.out_en_n = 1'b1;
                end
                if (phase_end) begin
                    nxt_wait = 32'h0000_0000;
                    // A running wake sequence goes back for its next row
                    nxt_state = wake_ff != 4'h0 ? dcc_pkg::DCC_ST_WAKE
                        : dcc_pkg::DCC_ST_IDLE;
                end
            end
            default: begin
                nxt_state = dcc_pkg::DCC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= dcc_pkg::DCC_ST_POWERUP;
            cur_ff <= '0;
            pins_ff <= '{row_low_n: 1'b1, row_high_n: 1'b1, col_n: 4'hF,
                write_n: 1'b1, out_en_n: 1'b1, addr: 10'h000};
            wait_ff <= 32'h0000_0000;
            wake_ff <= 4'h0;
            drive_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
            pd_done_ff <= 1'b0;
            pd_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            pins_ff <= nxt_pins;
            wait_ff <= nxt_wait;
            wake_ff <= nxt_wake;
            drive_ff <= nxt_drive;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            pd_done_ff <= nxt_pd_done;
            pd_ff <= nxt_pd;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign req_ready = state_ff == dcc_pkg::DCC_ST_IDLE && !due && !overrun;
    assign rdata = rdata_ff;
    assign rdata_valid = rvalid_ff;
    assign busy_init = state_ff == dcc_pkg::DCC_ST_POWERUP
        || state_ff == dcc_pkg::DCC_ST_WAKE || wake_ff != 4'h0;
    assign refresh_late = overrun;
    assign pins = pins_ff;
    assign data_lines_out = cur_ff.wdata;
    assign data_lines_oe_n = {dcc_pkg::DATA_W{!drive_ff}};
    assign presence_id = pd_ff;

endmodule // dcc_host

// ==== dcc_host_monitor.sv ====
`timescale 1ns/1ps
// ********
// Host strobe checker
// ********
module dcc_host_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire dcc_pkg::dcc_req_s req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rdata_valid,
    input wire logic busy_init,
    input wire logic refresh_late,
    input wire dcc_pkg::dcc_pins_s pins,
    input wire logic [dcc_pkg::DATA_W-1:0] data_lines_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Gating, strobe order and data direction on the card pins
    init_gate_a: assert property (
        busy_init |-> !req_ready) else $error("request ready during init");
    late_gate_a: assert property (
        refresh_late |-> !req_ready) else $error("request ready while refresh late");
    column_first_a: assert property (
        $fell(pins.row_low_n) && !pins.row_high_n |-> $past(pins.col_n) == 4'h0)
        else $error("dual row fall without column first");
    row_first_a: assert property (
        pins.col_n != 4'hF && $past(pins.col_n) == 4'hF && !(pins.row_low_n && pins.row_high_n)
        |-> !($past(pins.row_low_n) && $past(pins.row_high_n)))
        else $error("column strobe before row strobe");
    // Data must be on the lines while a write strobe pair is low
    write_drive_a: assert property (
        !pins.write_n && (pins.row_low_n ^ pins.row_high_n) && pins.col_n != 4'hF
        |-> data_lines_oe_n != 32'hFFFF_FFFF) else $error("write without data driven");
    // Contention hazard: card drives while output-enable low in a read
    bus_free_a: assert property (
        pins.write_n && !pins.out_en_n && pins.col_n != 4'hF
        |-> data_lines_oe_n == 32'hFFFF_FFFF) else $error("host drives during read");
    oe_before_write_a: assert property (
        $fell(pins.write_n) && pins.col_n != 4'hF && (pins.row_low_n ^ pins.row_high_n)
        |-> pins.out_en_n && $past(pins.out_en_n)) else $error("late write with oe low");
    col_up_a: assert property (
        $rose(pins.row_low_n) || $rose(pins.row_high_n) |-> pins.col_n == 4'hF)
        else $error("row strobe rose with column low");
    read_answer_a: assert property (
        req_valid && req_ready && req.cmd == dcc_pkg::DCC_CMD_READ |-> ##[6:12] rdata_valid)
        else $error("read answer missing");
endmodule // dcc_host_monitor

bind dcc_host dcc_host_monitor dcc_host_monitor_i (.clock(clock), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata_valid(rdata_valid),
    .busy_init(busy_init), .refresh_late(refresh_late), .pins(pins),
    .data_lines_oe_n(data_lines_oe_n));

// ==== dcc_card_model.sv ====
`timescale 1ns/1ps
// ********
// Card model decoding strobe edges
// ********
module dcc_card_model #(
    parameter logic [7:0] PRESENCE = 8'hA5 // Arbitrary personality code
) (
    input wire logic clock,
    input wire dcc_pkg::dcc_pins_s pins,
    input wire logic [31:0] data_lines_out,
    input wire logic [31:0] data_lines_oe_n,
    output logic [31:0] data_lines_in,
    output logic [7:0] presence_id_pins
);
    logic [31:0] mem [int];
    logic [31:0] word_ff = 32'h0;
    logic [31:0] last_ff = 32'h0;
    logic [3:0] colp_ff = 4'hF;
    logic [1:0] rowp_ff = 2'b11;
    logic [10:0] row_ff = 11'h0;
    logic wep_ff = 1'b1;
    logic early_ff = 1'b0;
    logic cbr_ff = 1'b0;
    logic act;
    logic drive;
    int key;
    int key_ff = 0;
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [3:0] ln,
                                          input logic [31:0] d);
        for (int i = 0; i < 4; i++)
            if (ln[i])
                o[8*i +: 8] = d[8*i +: 8];
        return o;
    endfunction
    // Released lines show garbage, never the last value
    assign act = !(pins.row_low_n && pins.row_high_n);
    assign drive = act && pins.col_n != 4'hF && !pins.out_en_n && !early_ff && !cbr_ff;
    assign data_lines_in = drive ? word_ff
                         : (data_lines_out & ~data_lines_oe_n) | (~last_ff & data_lines_oe_n);
    assign presence_id_pins = PRESENCE;
    // Edge decode; undriven host bits corrupt stored bytes
    always @(posedge clock) begin
        last_ff <= data_lines_in;
        colp_ff <= pins.col_n;
        rowp_ff <= {pins.row_low_n, pins.row_high_n};
        wep_ff <= pins.write_n;
        if (rowp_ff == 2'b11 && act) begin
            cbr_ff <= pins.col_n != 4'hF;
            row_ff <= {!pins.row_high_n, pins.addr};
        end
        if (colp_ff == 4'hF && pins.col_n != 4'hF && act) begin
            key = {row_ff, pins.addr};
            key_ff <= key;
            early_ff <= !pins.write_n;
            word_ff <= mem.exists(key) ? mem[key] : 32'h0;
            if (!pins.write_n)
                mem[key] = merge(mem.exists(key) ? mem[key] : 32'h0, ~pins.col_n,
                                 data_lines_out ^ data_lines_oe_n);
        end
        if (wep_ff && !pins.write_n && act && !cbr_ff && colp_ff != 4'hF)
            mem[key_ff] = merge(mem.exists(key_ff) ? mem[key_ff] : 32'h0, ~pins.col_n,
                                data_lines_out ^ data_lines_oe_n);
    end
endmodule // dcc_card_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
// ********
// Host controller bench
// ********
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    dcc_pkg::dcc_req_s req = '0;
    logic req_ready, rdata_valid, busy_init, refresh_late;
    logic [31:0] rdata, dl_in, dl_out, dl_oe_n, e;
    logic [31:0] seed = 32'h0000_004E;
    logic [7:0] pd_pins, pd;
    dcc_pkg::dcc_pins_s pins;
    int checks = 0;
    int miscompares = 0;
    int wakes = 0;
    int cbrs = 0;
    int base = 0;
    logic row_prev = 1'b1;
    logic [31:0] exp_q[$];
    logic [31:0] shadow [int];
    logic [20:0] keys [8];
    dcc_pkg::dcc_cmd_e wcmd [3] = '{dcc_pkg::DCC_CMD_EARLY_WRITE, dcc_pkg::DCC_CMD_LATE_WRITE,
                                   dcc_pkg::DCC_CMD_RMW};
    dcc_pkg::dcc_cmd_e rcmd [3] = '{dcc_pkg::DCC_CMD_REFRESH_ROW, dcc_pkg::DCC_CMD_REFRESH_CBR,
                                   dcc_pkg::DCC_CMD_TEST_ENTRY};
    dcc_host #(.POWERUP_WAIT(20)) dcc_host_i (.clock(clock), .rst(rst), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
        .busy_init(busy_init), .refresh_late(refresh_late), .pins(pins), .data_lines_in(dl_in),
        .data_lines_out(dl_out), .data_lines_oe_n(dl_oe_n), .presence_id_pins(pd_pins),
        .presence_id(pd));
    dcc_card_model #(.PRESENCE(8'hA5)) dcc_card_model_i (.clock(clock), .pins(pins),
        .data_lines_out(dl_out), .data_lines_oe_n(dl_oe_n), .data_lines_in(dl_in),
        .presence_id_pins(pd_pins));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One request; shadow memory predicts the card's answer
    task automatic issue(input dcc_pkg::dcc_cmd_e c, input logic [20:0] k, input logic [3:0] ln);
        int n;
        logic [31:0] w;
        @(posedge clock);
        n = 0;
        seed = lfsr(seed);
        w = shadow.exists(k) ? shadow[k] : 32'h0;
        if (c == dcc_pkg::DCC_CMD_READ || c == dcc_pkg::DCC_CMD_RMW)
            exp_q.push_back(w);
        for (int i = 0; i < 4; i++)
            if (ln[i] && c inside {dcc_pkg::DCC_CMD_EARLY_WRITE, dcc_pkg::DCC_CMD_LATE_WRITE,
                                   dcc_pkg::DCC_CMD_RMW})
                w[8*i +: 8] = seed[8*i +: 8];
        shadow[k] = w;
        req <= '{c, k[20], ln, k[19:10], k[9:0], seed};
        req_valid <= 1'b1;
        do begin
            @(negedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 20000);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask
    // Read back the eight words named in keys
    task automatic read_all();
        for (int i = 0; i < 8; i++)
            issue(dcc_pkg::DCC_CMD_READ, keys[i], 4'hF);
    endtask
    // Clock
    initial begin
        forever #10 clock = ~clock;
    end
    // Result watcher; an answer with nothing expected cannot match
    always @(posedge clock) begin
        if (rdata_valid === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : ~rdata;
            `CHK("rdata", e, rdata)
        end
    end
    // Row strobe falls: wake refreshes, and dual-bank column-first cycles
    always @(posedge clock) begin
        row_prev <= pins.row_low_n;
        if (row_prev === 1'b1 && pins.row_low_n === 1'b0) begin
            if (busy_init === 1'b1)
                wakes <= wakes + 1;
            if (pins.row_high_n === 1'b0)
                cbrs <= cbrs + 1;
        end
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(negedge clock);
        `CHK("busy_init", 1'b1, busy_init)
        `CHK("presence_id", 8'hA5, pd)
        for (int n = 0; n < 2000 && busy_init !== 1'b0; n++)
            @(negedge clock);
        `CHK("wake refreshes", dcc_pkg::WAKEUP_REFRESHES, wakes)
        foreach (wcmd[j]) begin
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                keys[i] = seed[20:0];
                issue(wcmd[j], keys[i], (i == 0 || j == 2) ? 4'hF : seed[24:21] | 4'h1);
            end
            read_all();
            $display("test %s done", wcmd[j].name());
        end
        foreach (rcmd[j])
            issue(rcmd[j], keys[j], 4'hF);
        read_all();
        $display("test refresh modes done");
        base = cbrs;
        repeat (7000) @(posedge clock);
        `CHK("refresh_late", 1'b0, refresh_late)
        `CHK("auto refreshes", 1, cbrs - base)
        read_all();
        repeat (20) @(posedge clock);
        `CHK("pending reads", 0, exp_q.size())
        $display("test refresh interval done");
        summarize();
    end
endmodule // tb_top
